// ==== pkg/mpw_pkg.sv ====
// Register map, field layout and constants of the motor PWM block
package mpw_pkg;
   localparam int unsigned AW = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL1   = 8'h00;
   localparam logic [7:0] OFS_CTRL2   = 8'h04;
   localparam logic [7:0] OFS_MODULUS = 8'h08;
   localparam logic [7:0] OFS_DEAD    = 8'h0C;
   localparam logic [7:0] OFS_OUTCTL  = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_DUTY0   = 8'h20;
   // CTRL1 fields
   localparam int unsigned C1_ENABLE  = 0;
   localparam int unsigned C1_PERMIT  = 1;
   localparam int unsigned C1_IRQEN   = 2;
   localparam int unsigned C1_FLAG    = 3;
   localparam int unsigned C1_INDEPENDENT_MODE_OPT   = 4;
   localparam int unsigned C1_SWOUT   = 5;
   localparam int unsigned C1_SENSE   = 8;
   // CTRL2 fields
   localparam int unsigned C2_DIV     = 0;
   localparam int unsigned C2_RATE    = 2;
   // Reset values, duty clamp limits and bus response codes
   localparam logic [11:0] MODULUS_RST = 12'h0_FFF;
   localparam logic [7:0]  DEAD_RST    = 8'hFF;
   localparam logic [11:0] DUTY_MAX    = 12'hF_FF;
   localparam logic [15:0] OVF_LO      = 16'h1000;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   typedef enum logic [2:0]
   {
      DT_IDLE  = 3'b001,
      DT_WAIT  = 3'b010,
      DT_RUN   = 3'b100
   } mpw_dt_t;
endpackage

// ==== hdl/mpw_core.sv ====
// Six-channel motor PWM with buffered reload, duty clamp and dead time
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// RL1: Reload every 1, 2, 4 or 8 PWM cycles by rate field.
// RL2: New reload rate takes effect after the running reload cycle ends.
// RL3: Reading the rate field returns the last written buffered value.
// RL4: Interrupt request raised when reload flag sets and enable is on.
// RL5: Interrupt enable clear suppresses requests; reloads continue.
// RL6: No modulus, divider or duty transfer without load permit set.
// RL7: With permit, copy buffers to active set at reload; clear permit.
// RL8: Enabling module loads if permitted and flags reload anyway.
// RL9: Software should clear interrupt enable before enabling module.
// RL10: Duty registers accept 16-bit signed values; counter is 12 bits.
// RL11: Duty 0x1000..0x7FFF clamps to FFF; 0x8000 upward clamps to 000.
// RL12: Duty at or below zero keeps output inactive all period.
// RL13: Duty at or above modulus keeps output active all period.
// RL14: Option selects six independent channels or three pairs.
// RL15: Pairs use one duty register each; independent uses own register.
// RL16: Dead time is 8-bit CPU clock count, independent of divider.
// RL17: Dead time register accepts one write only.
// RL18: Top generator output feeds dead time; bottom derived from top.
// RL19: Each dead time input transition forces both outputs inactive.
// RL20: Software output control: even bits feed dead time, odd set bottom.
// RL21: Sense select picks which pair duty drives top next PWM cycle.
// RL22: Reload flag sets at every reload boundary, load or not.
// RL23: Divider 1,2,4,8 buffered, applied only on permitted reload.
// RL24: Interrupt stays high while flag and enable set until cleared.
module mpw_core
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [5:0]       pwmOut,
   output logic             reloadIrq
);
   // Control and buffered state
   logic        moduleEnable;
   logic        loadPermit;
   logic        reloadIrqEnable;
   logic        reloadFlag;
   logic        independentModeOpt;
   logic        swOutEnable;
   logic [2:0]  senseSel;
   logic [1:0]  clockDivideSel;
   logic [1:0]  reloadRateSel;
   logic [5:0]  swOutputBits;
   logic [11:0] modulusBuf;
   logic [7:0]  deadCount;
   logic        deadWritten;
   logic [15:0] dutyValue [6];
   // Active set
   logic [11:0] actModulus;
   logic [1:0]  actDivide;
   logic [1:0]  actRate;
   logic [11:0] actDuty [6];
   logic [2:0]  actSense;
   // Timebase
   logic [2:0]  preCnt;
   logic [11:0] pwmCnt;
   logic [2:0]  cycCnt;
   logic        enableDly;
   logic        pwmTick;
   logic        cycleEnd;
   logic        reloadNow;
   logic        enableRise;
   // Bus
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddr;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        doWrite;
   logic        flagClear;
   logic [31:0] readMux;
   logic        readOk;

   // Write path: address and data taken in either order, response after both
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         awHeld <= 1'b0;
         wHeld  <= 1'b0;
         awAddr <= 8'h00;
         wData  <= 32'h0000_0000;
         wStrb  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= mpw_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr[1:0] != 2'b00 || awAddr > mpw_pkg::OFS_DUTY0 + 8'h14 ||
                             (awAddr > mpw_pkg::OFS_STATUS && awAddr < mpw_pkg::OFS_DUTY0))
                            ? mpw_pkg::RESP_SLVERR : mpw_pkg::RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Ready only while nothing of its kind is pending
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   assign doWrite   = awHeld && wHeld && !s_axi_bvalid;
   assign flagClear = doWrite && awAddr == mpw_pkg::OFS_CTRL1 && wStrb[0]
                      && !wData[mpw_pkg::C1_FLAG];

   // Software-written control bits
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         moduleEnable       <= 1'b0;
         reloadIrqEnable    <= 1'b0;
         independentModeOpt <= 1'b0;
         swOutEnable        <= 1'b0;
         senseSel           <= 3'h0;
         clockDivideSel     <= 2'h0;
         reloadRateSel      <= 2'h0;
         swOutputBits       <= 6'h00;
         modulusBuf         <= mpw_pkg::MODULUS_RST;
         deadCount          <= mpw_pkg::DEAD_RST;
         deadWritten        <= 1'b0;
      end
      else if (doWrite)
      begin
         case (awAddr)
            mpw_pkg::OFS_CTRL1:
            begin
               if (wStrb[0])
               begin
                  moduleEnable       <= wData[mpw_pkg::C1_ENABLE];
                  reloadIrqEnable    <= wData[mpw_pkg::C1_IRQEN];
                  independentModeOpt <= wData[mpw_pkg::C1_INDEPENDENT_MODE_OPT]; // RL14
                  swOutEnable        <= wData[mpw_pkg::C1_SWOUT];
               end
               if (wStrb[1])
                  senseSel <= wData[mpw_pkg::C1_SENSE +: 3];
            end
            mpw_pkg::OFS_CTRL2:
               if (wStrb[0])
               begin
                  clockDivideSel <= wData[mpw_pkg::C2_DIV +: 2];
                  reloadRateSel  <= wData[mpw_pkg::C2_RATE +: 2]; // RL2
               end
            mpw_pkg::OFS_MODULUS:
            begin
               if (wStrb[0])
                  modulusBuf[7:0] <= wData[7:0];
               if (wStrb[1])
                  modulusBuf[11:8] <= wData[11:8];
            end
            mpw_pkg::OFS_DEAD:
               if (wStrb[0] && !deadWritten)
               begin
                  deadCount   <= wData[7:0]; // RL17
                  deadWritten <= 1'b1;
               end
            mpw_pkg::OFS_OUTCTL:
               if (wStrb[0])
                  swOutputBits <= wData[5:0];
            default:
               moduleEnable <= moduleEnable;
         endcase
      end
   end

   // Duty registers, full 16-bit signed value stored
   for (genvar i = 0; i < 6; i++)
   begin : g_duty
      always_ff @(posedge clk)
      begin
         if (!rst_n)
            dutyValue[i] <= 16'h0000;
         else if (doWrite && awAddr == mpw_pkg::OFS_DUTY0 + 8'(4 * i))
         begin
            if (wStrb[0])
               dutyValue[i][7:0] <= wData[7:0]; // RL10
            if (wStrb[1])
               dutyValue[i][15:8] <= wData[15:8];
         end
      end
   end

   // Timebase: divided tick, edge-aligned up counter 1..modulus
   assign pwmTick    = (preCnt == 3'((4'd1 << actDivide) - 4'd1));
   assign cycleEnd   = moduleEnable && pwmTick && pwmCnt >= actModulus;
   assign enableRise = moduleEnable && !enableDly;
   assign reloadNow  = (cycleEnd && cycCnt == 3'((4'd1 << actRate) - 4'd1)) // RL1
                       || enableRise; // RL8

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         preCnt    <= 3'h0;
         pwmCnt    <= 12'h001;
         cycCnt    <= 3'h0;
         enableDly <= 1'b0;
      end
      else
      begin
         enableDly <= moduleEnable;
         if (!moduleEnable || enableRise)
         begin
            preCnt <= 3'h0;
            pwmCnt <= 12'h001;
            cycCnt <= 3'h0;
         end
         else
         begin
            preCnt <= pwmTick ? 3'h0 : preCnt + 3'h1; // RL23
            if (pwmTick)
               pwmCnt <= cycleEnd ? 12'h001 : pwmCnt + 12'h001;
            if (reloadNow)
               cycCnt <= 3'h0;
            else if (cycleEnd)
               cycCnt <= cycCnt + 3'h1;
         end
      end
   end

   // Reload: rate always follows, parameters only with permit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         actModulus <= mpw_pkg::MODULUS_RST;
         actDivide  <= 2'h0;
         actRate    <= 2'h0;
         actSense   <= 3'h0;
         loadPermit <= 1'b0;
      end
      else
      begin
         if (cycleEnd || enableRise)
            actSense <= enableRise ? 3'h0 : senseSel; // RL21
         if (reloadNow)
            actRate <= reloadRateSel; // RL2
         if (reloadNow && loadPermit)
         begin
            actModulus <= modulusBuf; // RL7
            actDivide  <= clockDivideSel; // RL23
            loadPermit <= 1'b0; // RL7
         end
         else if (doWrite && awAddr == mpw_pkg::OFS_CTRL1 && wStrb[0]
                  && wData[mpw_pkg::C1_PERMIT])
            loadPermit <= 1'b1;
      end
   end

   // Active duty, clamped on transfer
   for (genvar i = 0; i < 6; i++)
   begin : g_act
      always_ff @(posedge clk)
      begin
         if (!rst_n)
            actDuty[i] <= 12'h000;
         else if (reloadNow && loadPermit) // RL6
         begin
            if (dutyValue[i][15])
               actDuty[i] <= 12'h000; // RL11
            else if (dutyValue[i] >= mpw_pkg::OVF_LO)
               actDuty[i] <= mpw_pkg::DUTY_MAX; // RL11
            else
               actDuty[i] <= dutyValue[i][11:0];
         end
      end
   end

   // Reload flag: set wins over clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reloadFlag <= 1'b0;
      else if (reloadNow)
         reloadFlag <= 1'b1; // RL22
      else if (flagClear)
         reloadFlag <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reloadIrq <= 1'b0;
      else
         reloadIrq <= reloadIrqEnable && (reloadFlag || reloadNow) // RL4 RL5
                      && !(flagClear && !reloadNow); // RL24
   end

   // Generators, dead time and outputs per pair
   logic [5:0] genOut;
   for (genvar i = 0; i < 6; i++)
   begin : g_gen
      // Count runs 1..modulus; duty 0 never active, duty >= modulus always active
      assign genOut[i] = moduleEnable && actDuty[i] != 12'h000 // RL12
                         && (pwmCnt <= actDuty[i] || actDuty[i] >= actModulus); // RL13
   end

   for (genvar p = 0; p < 3; p++)
   begin : g_pair
      logic       topSrc;
      logic       botWant;
      logic       prevSrc;
      logic [7:0] dtCnt;
      logic       topQ;
      logic       botQ;
      // Top source: sense picks odd or even duty for the pair
      assign topSrc  = swOutEnable ? swOutputBits[2 * p] // RL20
                       : genOut[2 * p + 32'(actSense[p])]; // RL15 RL21
      assign botWant = swOutEnable ? swOutputBits[2 * p + 1] : !topSrc; // RL18 RL20
      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            prevSrc <= 1'b0;
            dtCnt   <= 8'h00;
         end
         else
         begin
            prevSrc <= topSrc;
            if (topSrc != prevSrc)
               dtCnt <= deadCount; // RL16 RL19
            else if (dtCnt != 8'h00)
               dtCnt <= dtCnt - 8'h01;
         end
      end
      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            topQ <= 1'b0;
            botQ <= 1'b0;
         end
         else if (!moduleEnable)
         begin
            topQ <= 1'b0;
            botQ <= 1'b0;
         end
         else if (independentModeOpt)
         begin
            topQ <= genOut[2 * p]; // RL15
            botQ <= genOut[2 * p + 1];
         end
         else if (topSrc != prevSrc || dtCnt > 8'h01)
         begin
            topQ <= 1'b0; // RL19
            botQ <= 1'b0;
         end
         else
         begin
            topQ <= topSrc;
            botQ <= botWant && !topSrc;
         end
      end
      assign pwmOut[2 * p]     = topQ;
      assign pwmOut[2 * p + 1] = botQ;
   end

   // Read path
   always_comb
   begin
      readMux = 32'h0000_0000;
      readOk  = s_axi_araddr[1:0] == 2'b00;
      case (s_axi_araddr)
         mpw_pkg::OFS_CTRL1:
         begin
            readMux[mpw_pkg::C1_ENABLE] = moduleEnable;
            readMux[mpw_pkg::C1_PERMIT] = loadPermit;
            readMux[mpw_pkg::C1_IRQEN]  = reloadIrqEnable;
            readMux[mpw_pkg::C1_FLAG]   = reloadFlag;
            readMux[mpw_pkg::C1_INDEPENDENT_MODE_OPT]  = independentModeOpt;
            readMux[mpw_pkg::C1_SWOUT]  = swOutEnable;
            readMux[mpw_pkg::C1_SENSE +: 3] = senseSel;
         end
         mpw_pkg::OFS_CTRL2:
         begin
            readMux[mpw_pkg::C2_DIV +: 2]  = clockDivideSel;
            readMux[mpw_pkg::C2_RATE +: 2] = reloadRateSel; // RL3
         end
         mpw_pkg::OFS_MODULUS: readMux[11:0] = modulusBuf;
         mpw_pkg::OFS_DEAD:    readMux[7:0]  = deadCount;
         mpw_pkg::OFS_OUTCTL:  readMux[5:0]  = swOutputBits;
         mpw_pkg::OFS_STATUS:  readMux[11:0] = pwmCnt;
         default:
         begin
            readOk = 1'b0;
            for (int k = 0; k < 6; k++)
               if (s_axi_araddr == mpw_pkg::OFS_DUTY0 + 8'(4 * k))
               begin
                  readMux[15:0] = dutyValue[k];
                  readOk        = 1'b1;
               end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= mpw_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readMux;
            s_axi_rresp  <= readOk ? mpw_pkg::RESP_OKAY : mpw_pkg::RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   sequence sq_reload_permit;
      reloadNow && loadPermit;
   endsequence

   AST_PERMIT_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // RL7
      sq_reload_permit |=> !loadPermit && actModulus == $past(modulusBuf))
      else $error("Permit not cleared or modulus not loaded");
   AST_NO_LOAD: assert property (@(posedge clk) disable iff (!rst_n) // RL6
      (reloadNow && !loadPermit) |=> $stable(actModulus) && $stable(actDivide))
      else $error("Parameters moved without permit");
   AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n) // RL22
      reloadNow |=> reloadFlag)
      else $error("Reload flag not set at boundary");
   AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RL4
      (reloadNow && reloadIrqEnable) |=> reloadIrq)
      else $error("Interrupt missing on reload");
   AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rst_n) // RL5
      !$past(reloadIrqEnable) |-> !reloadIrq)
      else $error("Interrupt while disabled");
   AST_RATE: assert property (@(posedge clk) disable iff (!rst_n) // RL1
      cycleEnd |-> cycCnt <= 3'((4'd1 << actRate) - 4'd1))
      else $error("Reload rate count wrong");
   AST_DEAD_ONCE: assert property (@(posedge clk) disable iff (!rst_n) // RL17
      $past(deadWritten) |-> $stable(deadCount))
      else $error("Dead time changed after first write");
   AST_CLAMP: assert property (@(posedge clk) disable iff (!rst_n) // RL11
      sq_reload_permit ##1 $past(dutyValue[2][15]) |-> actDuty[2] == 12'h000)
      else $error("Negative duty not clamped");
endmodule

// ==== bench/mpw_inverter_leg.sv ====
// Inverter leg model: three top/bottom switch pairs driven by the PWM pins
`timescale 1ns/1ps
module mpw_inverter_leg
(
   input  wire logic       clk,
   input  wire logic [5:0] gate,
   output int              shootThrough
);
   initial shootThrough = 0;
   // Both switches of one leg on at once short the supply rail
   always @(posedge clk)
   begin
      for (int p = 0; p < 3; p++)
      begin
         if (gate[2*p] === 1'b1 && gate[2*p+1] === 1'b1)
            shootThrough <= shootThrough + 1;
      end
   end
endmodule

// ==== bench/mpw_core_bench.sv ====
// Self-checking bench for the motor PWM core with a reference model
`timescale 1ns/1ps
module mpw_core_bench;
   localparam int MOD = 20;
   localparam int DT  = 3;
   logic        clk;
   logic        rst_n;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic [5:0]  pwmOut;
   logic        reloadIrq;
   int          shootThrough;
   int          n_mismatch;
   int          checked;
   int          cyc;
   logic        prevIrq;
   int          rise[$];
   int          hi[6];
   int          duty[6];
   int          c;
   int          d;
   int          st0;
   logic [1:0]  resp;
   logic [31:0] rdat;
   logic [31:0] ctl;

   mpw_core dut_u
   (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwmOut, .reloadIrq
   );

   mpw_inverter_leg leg_u
   (
      .clk(clk),
      .gate(pwmOut),
      .shootThrough(shootThrough)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cycle stamps of each interrupt rise give the reload interval
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      prevIrq <= reloadIrq;
      if (reloadIrq === 1'b1 && prevIrq === 1'b0)
         rise.push_back(cyc);
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %0h seen %0h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   // ctl never carries the flag bit, so rewriting it clears the flag
   task automatic waitIrq(input int n);
      repeat (n)
      begin
         while (reloadIrq !== 1'b1)
            @(posedge clk);
         wr(mpw_pkg::OFS_CTRL1, ctl);
         @(posedge clk);
         chk("irq cleared", 0, reloadIrq);
      end
   endtask

   task automatic load();
      wr(mpw_pkg::OFS_CTRL1, ctl | 32'h0000_0002);
      do
         rd(mpw_pkg::OFS_CTRL1);
      while (rdat[mpw_pkg::C1_PERMIT] !== 1'b0);
      repeat (45) @(posedge clk);
   endtask

   task automatic countHigh();
      hi = '{default: 0};
      repeat (MOD)
      begin
         @(posedge clk);
         for (int i = 0; i < 6; i++)
            hi[i] += (pwmOut[i] === 1'b1);
      end
   endtask

   function automatic int usedDuty(input int v);
      if (v >= 16'h8000)
         return 0;
      if (v >= 16'h1000)
         return (12'hFFF < MOD) ? 12'hFFF : MOD;
      return (v < MOD) ? v : MOD;
   endfunction

   // Dead time eats one interval from every pulse that has edges
   function automatic int pairHigh(input int u, input bit bot);
      int w;
      w = bot ? MOD - u : u;
      if (u == 0 || u == MOD)
         return w;
      return (w > DT) ? w - DT : 0;
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      // Slowest case (rate 8, divide 8) needs about 11,000 cycles in all
      #(40 * 30_000);
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      rst_n = 1'b0;
      {cyc, prevIrq, n_mismatch, checked, ctl} = '0;
      void'($urandom(32'h0000_fdf3));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("pwm at reset", 0, pwmOut);
      rd(mpw_pkg::OFS_DEAD);
      chk("dead reset", 8'hFF, rdat);
      wr(mpw_pkg::OFS_DEAD, DT);
      wr(mpw_pkg::OFS_DEAD, 8'h10);
      rd(mpw_pkg::OFS_DEAD);
      chk("dead once", DT, rdat);
      wr(8'h40, 32'h0000_0001);
      chk("unmapped wr", mpw_pkg::RESP_SLVERR, resp);
      rd(8'h40);
      chk("unmapped rd", mpw_pkg::RESP_SLVERR, resp);
      wr(mpw_pkg::OFS_MODULUS, MOD);
      duty = '{16'h0000, 16'h7FFF, 16'h8000, 16'h0005, 16'h0014, 1 + $urandom % 19};
      for (int i = 0; i < 6; i++)
         wr(mpw_pkg::OFS_DUTY0 + 8'(4 * i), duty[i]);
      ctl = 32'h0000_0010;
      wr(mpw_pkg::OFS_CTRL1, ctl | 32'h0000_0002);
      ctl = ctl | 32'h0000_0001;
      wr(mpw_pkg::OFS_CTRL1, ctl);
      rd(mpw_pkg::OFS_CTRL1);
      chk("flag on enable", 1, rdat[mpw_pkg::C1_FLAG]);
      chk("permit after load", 0, rdat[mpw_pkg::C1_PERMIT]);
      chk("irq disabled", 0, reloadIrq);
      repeat (45) @(posedge clk);
      countHigh();
      for (int i = 0; i < 6; i++)
         chk("independent_mode_opt high", usedDuty(duty[i]), hi[i]);
      ctl = 32'h0000_0015;
      for (int r = 0; r < 4; r++)
      begin
         d = $urandom % 4;
         wr(mpw_pkg::OFS_CTRL2, 4 * r + d);
         rd(mpw_pkg::OFS_CTRL2);
         chk("rate readback", 4 * r + d, rdat[3:0]);
         wr(mpw_pkg::OFS_CTRL1, ctl | 32'h0000_0002);
         waitIrq(4);
         chk("reload interval", MOD << (d + r), rise[$] - rise[$-1]);
      end
      wr(mpw_pkg::OFS_CTRL2, 32'h0000_0000);
      waitIrq(4);
      chk("no permit div", MOD << d, rise[$] - rise[$-1]);
      wr(mpw_pkg::OFS_CTRL1, ctl | 32'h0000_0002);
      waitIrq(4);
      chk("permit div", MOD, rise[$] - rise[$-1]);
      ctl = 32'h0000_0011;
      wr(mpw_pkg::OFS_CTRL1, ctl);
      repeat (60) @(posedge clk);
      rd(mpw_pkg::OFS_CTRL1);
      chk("flag w/o irq", 1, rdat[mpw_pkg::C1_FLAG]);
      chk("irq masked", 0, reloadIrq);
      ctl = 32'h0000_0001;
      duty = '{12, 6, 16'h7FFF, 0, 0, 9};
      for (int i = 0; i < 6; i++)
         wr(mpw_pkg::OFS_DUTY0 + 8'(4 * i), duty[i]);
      // Independent channels may overlap legally; pairs are judged from here on
      st0 = shootThrough;
      load();
      countHigh();
      for (int p = 0; p < 3; p++)
      begin
         c = usedDuty(duty[2*p]);
         chk("pair top", pairHigh(c, 0), hi[2*p]);
         chk("pair bottom", pairHigh(c, 1), hi[2*p+1]);
      end
      ctl = 32'h0000_0101;
      wr(mpw_pkg::OFS_CTRL1, ctl);
      repeat (45) @(posedge clk);
      countHigh();
      c = usedDuty(duty[1]);
      chk("sense top", pairHigh(c, 0), hi[0]);
      chk("sense bottom", pairHigh(c, 1), hi[1]);
      wr(mpw_pkg::OFS_OUTCTL, 32'h0000_0001);
      ctl = 32'h0000_0021;
      wr(mpw_pkg::OFS_CTRL1, ctl);
      repeat (10) @(posedge clk);
      chk("sw output", 2'b01, pwmOut[1:0]);
      chk("shoot through", st0, shootThrough);
      print_verdict();
   end
endmodule
